// file: hw/psp_pkg.sv
/*
  Shared definitions of the pulse-skipping PWM channel: register
  offsets, control bit positions, reset values, output states and
  carrier structs.
  Assumes one clock domain (ref_clk) and an Avalon-MM slave with a
  32-bit data path and byte addressing.
*/
// Functional notes
// R1: At a period event, arm a pulse if any enabled rise source is high.
// R2: All enabled rise sources low at period event: skip, outputs stay idle.
// R3: Rising edge timing inside the period comes from the phase pair.
// R4: Any enabled fall event input ends the pulse, no qualification.
// R5: Primary waveform only on output A, complement only on output B.
// R6: Dead-band available on both rising and falling transitions.
// R7: Rise: complement off, rise dead-band if enabled, then primary on.
// R8: Fall: primary off, fall dead-band if enabled, then complement on.
// R9: Software should use an external source to qualify pulses.
// R10: Ten registers are double-buffered: period, duty, phase, dead, blank.
// R11: Steering register is buffered only while steering sync bit set.
// R12: Module disabled: writes to buffered registers load active copy too.
// R13: Enabled: load request copies all buffers at next period event.
// R14: Hardware clears the load request bit after the transfer.
// R15: Software writes all values first, then sets load request.
// R16: Keeps generating waveforms in sleep on internal or external clock.
// R17: Enabled without load request, writes leave active copies untouched.
package psp_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_PRL = 6'h04;
  localparam logic [5:0] ADDR_PRH = 6'h08;
  localparam logic [5:0] ADDR_DCL = 6'h0C;
  localparam logic [5:0] ADDR_DCH = 6'h10;
  localparam logic [5:0] ADDR_PHL = 6'h14;
  localparam logic [5:0] ADDR_PHH = 6'h18;
  localparam logic [5:0] ADDR_DBR = 6'h1C;
  localparam logic [5:0] ADDR_DBF = 6'h20;
  localparam logic [5:0] ADDR_BKR = 6'h24;
  localparam logic [5:0] ADDR_BKF = 6'h28;
  localparam logic [5:0] ADDR_STR = 6'h2C;
  localparam logic [5:0] ADDR_SRC = 6'h30;
  localparam logic [5:0] ADDR_STAT = 6'h34;

  // ****************************************************************
  // Control register bits
  // ****************************************************************
  localparam int CTRL_EN = 7;
  localparam int CTRL_LD = 6;
  localparam int CTRL_DBR_EN = 1;
  localparam int CTRL_DBF_EN = 0;
  localparam int STR_SYNC = 7;
  // Source enable register: rise enables [3:0], fall enables [7:4]
  localparam int SRC_RISE_LSB = 0;
  localparam int SRC_FALL_LSB = 4;
  localparam int NUM_SRC = 4;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] DB_ONE = 8'h01;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Carrier structs
  // ****************************************************************
  typedef struct packed {
    logic [7:0] prl;
    logic [7:0] prh;
    logic [7:0] dcl;
    logic [7:0] dch;
    logic [7:0] phl;
    logic [7:0] phh;
    logic [7:0] dbr;
    logic [7:0] dbf;
    logic [7:0] bkr;
    logic [7:0] bkf;
    logic [7:0] str;
  } psp_regs_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_DB_RISE = 3'b010,
    ST_HIGH = 3'b011,
    ST_DB_FALL = 3'b100
  } psp_wave_e;

endpackage : psp_pkg

// file: hw/psp_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to ref_clk.
*/
module psp_sync
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] value;
  } psp_sync_s;

  psp_sync_s st;
  psp_sync_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Change only once stages two and three agree
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.value[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.value;

endmodule // psp_sync

// file: hw/psp_top.sv
/*
  Pulse-skipping PWM channel with complementary outputs, dead-band
  and a double-buffered register set behind an Avalon-MM slave.
  Assumes event sources are asynchronous pins; ref_clk keeps running
  in sleep, so waveforms continue whatever the core does.
*/
module psp_top
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event source pins
  input wire logic [3:0] rise_src,
  input wire logic [3:0] fall_src,
  // Power stage outputs
  output logic primary_output,
  output logic complementary_output
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] module_control_reg;
    logic [7:0] src_enable;
    psp_pkg::psp_regs_s buffered;
    psp_pkg::psp_regs_s active;
    logic [15:0] period_cnt;
    logic [7:0] db_cnt;
    psp_pkg::psp_wave_e wave;
    logic [7:0] prev_src;
    logic rd_done;
    logic [31:0] rdata;
    logic pri;
    logic cmp;
  } psp_top_s;

  psp_top_s st;
  psp_top_s next_st;
  logic [7:0] src_sync;
  logic [3:0] rise_now;
  logic [3:0] fall_edge;
  logic [15:0] period_val;
  logic [15:0] phase_val;
  logic period_evt;
  logic phase_evt;
  logic wr_byte0;
  logic [7:0] wbyte;
  logic enabled;

  psp_sync #(.WIDTH(8)) u_sync
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({fall_src, rise_src}),
    .sync_out(src_sync)
  );

  function automatic logic [15:0] pair16(input logic [7:0] hi,
                                         input logic [7:0] lo);
    pair16 = {hi, lo};
  endfunction

  // Byte write into a buffered register; the active copy is not touched here
  function automatic logic [7:0] wr_sel(input logic [5:0] addr,
                                        input logic [5:0] match,
                                        input logic [7:0] old,
                                        input logic [7:0] val);
    wr_sel = (addr == match) ? val : old;
  endfunction

  // ****************************************************************
  // Event decode
  // ****************************************************************
  assign period_val = pair16(st.active.prh, st.active.prl);
  assign phase_val = pair16(st.active.phh, st.active.phl); // [R3]
  assign enabled = st.module_control_reg[psp_pkg::CTRL_EN];
  assign period_evt = enabled && (st.period_cnt >= period_val);
  assign phase_evt = enabled && (st.period_cnt == phase_val);
  assign rise_now = src_sync[psp_pkg::SRC_RISE_LSB +: psp_pkg::NUM_SRC] &
    st.src_enable[psp_pkg::SRC_RISE_LSB +: psp_pkg::NUM_SRC];
  // Any enabled fall source edge ends the pulse, no combination [R4]
  assign fall_edge = src_sync[psp_pkg::SRC_FALL_LSB +: psp_pkg::NUM_SRC] &
    ~st.prev_src[psp_pkg::SRC_FALL_LSB +: psp_pkg::NUM_SRC] &
    st.src_enable[psp_pkg::SRC_FALL_LSB +: psp_pkg::NUM_SRC];
  assign wr_byte0 = avs_write && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_comb
  begin
    next_st = st;
    next_st.prev_src = src_sync;
    next_st.rd_done = 1'b0;

    // **************************************************************
    // Period time base
    // **************************************************************
    if (!enabled)
    begin
      next_st.period_cnt = '0;
    end
    else if (period_evt)
    begin
      next_st.period_cnt = '0;
    end
    else
    begin
      next_st.period_cnt = st.period_cnt + psp_pkg::CNT_ONE; // [R16]
    end

    // **************************************************************
    // Register writes
    // **************************************************************
    if (wr_byte0)
    begin
      if (avs_address == psp_pkg::ADDR_CTRL)
      begin
        next_st.module_control_reg = wbyte;
      end
      else if (avs_address == psp_pkg::ADDR_SRC)
      begin
        next_st.src_enable = wbyte;
      end
      else
      begin
        next_st.buffered.prl = wr_sel(avs_address, psp_pkg::ADDR_PRL,
          st.buffered.prl, wbyte);
        next_st.buffered.prh = wr_sel(avs_address, psp_pkg::ADDR_PRH,
          st.buffered.prh, wbyte);
        next_st.buffered.dcl = wr_sel(avs_address, psp_pkg::ADDR_DCL,
          st.buffered.dcl, wbyte);
        next_st.buffered.dch = wr_sel(avs_address, psp_pkg::ADDR_DCH,
          st.buffered.dch, wbyte);
        next_st.buffered.phl = wr_sel(avs_address, psp_pkg::ADDR_PHL,
          st.buffered.phl, wbyte);
        next_st.buffered.phh = wr_sel(avs_address, psp_pkg::ADDR_PHH,
          st.buffered.phh, wbyte);
        next_st.buffered.dbr = wr_sel(avs_address, psp_pkg::ADDR_DBR,
          st.buffered.dbr, wbyte);
        next_st.buffered.dbf = wr_sel(avs_address, psp_pkg::ADDR_DBF,
          st.buffered.dbf, wbyte);
        next_st.buffered.bkr = wr_sel(avs_address, psp_pkg::ADDR_BKR,
          st.buffered.bkr, wbyte);
        next_st.buffered.bkf = wr_sel(avs_address, psp_pkg::ADDR_BKF,
          st.buffered.bkf, wbyte);
        next_st.buffered.str = wr_sel(avs_address, psp_pkg::ADDR_STR,
          st.buffered.str, wbyte);
      end
    end

    // **************************************************************
    // Double-buffer transfer
    // **************************************************************
    if (!enabled)
    begin
      // Disabled writes land in the active copy at once [R12] [R10]
      next_st.active = next_st.buffered;
    end
    else if (period_evt && st.module_control_reg[psp_pkg::CTRL_LD])
    begin
      next_st.active = st.buffered; // [R13] [R10]
      if (!st.buffered.str[psp_pkg::STR_SYNC])
      begin
        next_st.active.str = next_st.buffered.str; // [R11]
      end
      // A same-cycle software write to the control register wins over hardware done [R14]
      if (!(wr_byte0 && avs_address == psp_pkg::ADDR_CTRL))
      begin
        next_st.module_control_reg[psp_pkg::CTRL_LD] = 1'b0;
      end
    end
    else if (!next_st.buffered.str[psp_pkg::STR_SYNC])
    begin
      // Unsynchronised steering writes take effect directly [R11]
      next_st.active.str = next_st.buffered.str;
    end
    // Otherwise the active copy is left alone [R17]

    // **************************************************************
    // Waveform sequencer
    // **************************************************************
    if (!enabled)
    begin
      next_st.wave = psp_pkg::ST_IDLE;
      next_st.pri = 1'b0;
      next_st.cmp = 1'b0;
    end
    else
    begin
      case (st.wave)
        psp_pkg::ST_IDLE:
        begin
          // Skip the period when no enabled source is high [R2]
          if (period_evt && (rise_now != '0))
          begin
            next_st.wave = psp_pkg::ST_ARMED; // [R1]
          end
        end
        psp_pkg::ST_ARMED:
        begin
          if (phase_evt)
          begin
            next_st.cmp = 1'b0; // [R7] [R5]
            if (st.module_control_reg[psp_pkg::CTRL_DBR_EN] &&
                st.active.dbr != '0)
            begin
              next_st.db_cnt = st.active.dbr; // [R6]
              next_st.wave = psp_pkg::ST_DB_RISE;
            end
            else
            begin
              // One idle cycle keeps the switch break-before-make [R7]
              next_st.db_cnt = psp_pkg::DB_ONE;
              next_st.wave = psp_pkg::ST_DB_RISE;
            end
          end
        end
        psp_pkg::ST_DB_RISE:
        begin
          if (st.db_cnt <= psp_pkg::DB_ONE)
          begin
            next_st.pri = 1'b1; // [R7]
            next_st.wave = psp_pkg::ST_HIGH;
          end
          else
          begin
            next_st.db_cnt = st.db_cnt - psp_pkg::DB_ONE;
          end
        end
        psp_pkg::ST_HIGH:
        begin
          if (fall_edge != '0)
          begin
            next_st.pri = 1'b0; // [R8] [R5]
            if (st.module_control_reg[psp_pkg::CTRL_DBF_EN] &&
                st.active.dbf != '0)
            begin
              next_st.db_cnt = st.active.dbf; // [R6]
              next_st.wave = psp_pkg::ST_DB_FALL;
            end
            else
            begin
              next_st.db_cnt = psp_pkg::DB_ONE;
              next_st.wave = psp_pkg::ST_DB_FALL;
            end
          end
        end
        psp_pkg::ST_DB_FALL:
        begin
          if (st.db_cnt <= psp_pkg::DB_ONE)
          begin
            next_st.cmp = 1'b1; // [R8]
            next_st.wave = psp_pkg::ST_IDLE;
          end
          else
          begin
            next_st.db_cnt = st.db_cnt - psp_pkg::DB_ONE;
          end
        end
        default:
        begin
          next_st.wave = psp_pkg::ST_IDLE;
        end
      endcase
    end

    // **************************************************************
    // Read path
    // **************************************************************
    if (avs_read && !st.rd_done)
    begin
      next_st.rd_done = 1'b1;
      next_st.rdata = psp_pkg::READ_ZERO;
      if (avs_address == psp_pkg::ADDR_CTRL)
        next_st.rdata[7:0] = st.module_control_reg;
      else if (avs_address == psp_pkg::ADDR_SRC)
        next_st.rdata[7:0] = st.src_enable;
      else if (avs_address == psp_pkg::ADDR_STAT)
      begin
        next_st.rdata[15:0] = st.period_cnt;
        next_st.rdata[18:16] = st.wave;
        next_st.rdata[19] = st.pri;
        next_st.rdata[20] = st.cmp;
      end
      else if (avs_address == psp_pkg::ADDR_PRL)
        next_st.rdata[7:0] = st.buffered.prl;
      else if (avs_address == psp_pkg::ADDR_PRH)
        next_st.rdata[7:0] = st.buffered.prh;
      else if (avs_address == psp_pkg::ADDR_DCL)
        next_st.rdata[7:0] = st.buffered.dcl;
      else if (avs_address == psp_pkg::ADDR_DCH)
        next_st.rdata[7:0] = st.buffered.dch;
      else if (avs_address == psp_pkg::ADDR_PHL)
        next_st.rdata[7:0] = st.buffered.phl;
      else if (avs_address == psp_pkg::ADDR_PHH)
        next_st.rdata[7:0] = st.buffered.phh;
      else if (avs_address == psp_pkg::ADDR_DBR)
        next_st.rdata[7:0] = st.buffered.dbr;
      else if (avs_address == psp_pkg::ADDR_DBF)
        next_st.rdata[7:0] = st.buffered.dbf;
      else if (avs_address == psp_pkg::ADDR_BKR)
        next_st.rdata[7:0] = st.buffered.bkr;
      else if (avs_address == psp_pkg::ADDR_BKF)
        next_st.rdata[7:0] = st.buffered.bkf;
      else if (avs_address == psp_pkg::ADDR_STR)
        next_st.rdata[7:0] = st.buffered.str;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Reads take one wait cycle; writes complete at once
  assign avs_waitrequest = avs_read && !st.rd_done;
  assign avs_readdata = st.rdata;
  assign primary_output = st.pri;
  assign complementary_output = st.cmp;

endmodule // psp_top

// file: verif/psp_top_assertions.sv
/*
  Concurrent checks on the ports of psp_top.
  Assumes one clock, ref_clk, and reset_n active low.
*/
module psp_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Event pins and power stage
  input wire logic [3:0] rise_src,
  input wire logic [3:0] fall_src,
  input wire logic primary_output,
  input wire logic complementary_output
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  AST_NO_OVERLAP: assert property (
    !(primary_output && complementary_output))
    else $error("Both outputs active");
  AST_RISE_ORDER: assert property (
    $rose(primary_output) |-> !$past(complementary_output))
    else $error("Primary rose before complement left");
  AST_FALL_ORDER: assert property (
    $rose(complementary_output) |-> !$past(primary_output))
    else $error("Complement rose before primary left");
  // Bench stretches fall pulses to nine cycles
  AST_FALL_CAUSE: assert property (
    $fell(primary_output) |-> |$past(fall_src, 2))
    else $error("Pulse ended without a fall event");
  AST_RISE_BOUND: assert property (
    $fell(complementary_output) |-> ##[1:257] $rose(primary_output))
    else $error("Primary late after complement fell");
  AST_FALL_BOUND: assert property (
    $fell(primary_output) |-> ##[1:257] $rose(complementary_output))
    else $error("Complement late after primary fell");
  AST_STAT_OUTS: assert property (
    avs_read && !avs_waitrequest && avs_address == psp_pkg::ADDR_STAT
    |-> avs_readdata[20:19] ==
    {$past(complementary_output), $past(primary_output)})
    else $error("Status does not show the outputs");
  AST_RD_WAIT: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Read answer not one cycle late");
endmodule // psp_checker

bind psp_top psp_checker u_chk
(
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .rise_src(rise_src),
  .fall_src(fall_src),
  .primary_output(primary_output),
  .complementary_output(complementary_output)
);

// file: verif/psp_evt_model.sv
/*
  External event sources in front of the PWM channel.
  Assumes the bench asks for levels and one-cycle fall requests.
*/
module psp_evt_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requests from the bench
  input wire logic [3:0] rise_lvl,
  input wire logic [3:0] fall_req,
  // Event pins
  output logic [3:0] rise_src,
  output logic [3:0] fall_src
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] fall_cnt;

  // External qualifier, never the internal phase base
  assign rise_src = rise_lvl;

  // Stretched so the pin synchroniser cannot miss it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fall_src <= 4'h0;
      fall_cnt <= 4'h0;
    end
    else if (|fall_req)
    begin
      fall_src <= fall_req;
      fall_cnt <= 4'h8;
    end
    else if (fall_cnt != 4'h0)
      fall_cnt <= fall_cnt - 4'h1;
    else
      fall_src <= 4'h0;
  end
endmodule // psp_evt_model

// file: verif/tb_top.sv
/*
  Self-checking bench for psp_top over its Avalon-MM slave.
  Assumes psp_evt_model drives the event pins.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] RUN = 32'h83;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] rise_lvl = 4'h0;
  logic [3:0] fall_req = 4'h0;
  logic [3:0] rise_src;
  logic [3:0] fall_src;
  logic primary_output;
  logic complementary_output;
  logic [31:0] rdat;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int g_a;
  int g_b;
  int g_c;
  int bad;

  always #2 ref_clk = ~ref_clk;

  psp_top uut
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rise_src(rise_src),
    .fall_src(fall_src),
    .primary_output(primary_output),
    .complementary_output(complementary_output)
  );

  psp_evt_model u_evt
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rise_lvl(rise_lvl),
    .fall_req(fall_req),
    .rise_src(rise_src),
    .fall_src(fall_src)
  );

  // ************************************************************
  // Bus access and comparison
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Cycles from complement off to primary on, then end the pulse
  task automatic pulse(output int gap);
    gap = 0;
    while (complementary_output !== 1'b0)
      @(posedge ref_clk);
    while (primary_output !== 1'b1)
    begin
      @(posedge ref_clk);
      gap++;
    end
    fall_req <= 4'h1;
    @(posedge ref_clk);
    fall_req <= 4'h0;
    while (complementary_output !== 1'b1)
      @(posedge ref_clk);
    chk({31'h0, primary_output}, 32'h0);
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(psp_pkg::ADDR_DBR, rdat);
    chk(rdat, 32'h0);
    rd(6'h38, rdat);
    chk(rdat, 32'h0);
    // Disabled: each buffered-register write also lands in the active copy
    wr(psp_pkg::ADDR_PRL, 32'h40);
    wr(psp_pkg::ADDR_PHL, 32'h10);
    wr(psp_pkg::ADDR_DBR, 32'h02);
    wr(psp_pkg::ADDR_DBF, 32'h03);
    wr(psp_pkg::ADDR_SRC, 32'h11);
    rd(psp_pkg::ADDR_PRL, rdat);
    chk(rdat, 32'h40);
    rise_lvl <= 4'h1;
    wr(psp_pkg::ADDR_CTRL, RUN);
    pulse(g_a);
    pulse(g_a);
    chk(32'(g_a), 32'h2);
    // Enabled, no load request: waveform must not move
    wr(psp_pkg::ADDR_DBR, 32'h05);
    pulse(g_b);
    chk(32'(g_b), 32'(g_a));
    rd(psp_pkg::ADDR_DBR, rdat);
    chk(rdat, 32'h05);
    wr(psp_pkg::ADDR_CTRL, RUN | 32'h40);
    do rd(psp_pkg::ADDR_CTRL, rdat);
    while (rdat[6] !== 1'b0);
    chk(rdat, RUN);
    pulse(g_c);
    chk(32'(g_c - g_a), 32'h3);
    // Rise dead-band switched off shortens the gap
    wr(psp_pkg::ADDR_CTRL, 32'h81);
    pulse(g_b);
    chk(32'(g_b), 32'h1);
    // Only a source that is not enabled is high: skip
    rise_lvl <= 4'h2;
    bad = 0;
    repeat (200)
    begin
      @(posedge ref_clk);
      if (primary_output !== 1'b0 || complementary_output !== 1'b1)
        bad++;
    end
    chk(32'(bad), 32'h0);
    rd(psp_pkg::ADDR_STAT, rdat);
    chk({30'h0, rdat[20:19]}, 32'h2);
    wr(psp_pkg::ADDR_SRC, 32'h12);
    pulse(g_b);
    chk(32'(g_b), 32'h1);
    end_of_test();
  end
endmodule // tb_top
